/* File: core/i2csf_pkg.sv */
/*
 * i2csf_pkg: register map, field layouts, reset values, sequencer states and
 * timing counts of the i2c controller status-flag block.
 * assumes a 20 MHz system clock and a 400 ns bus bit period.
 */
package i2csf_pkg;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_DATA     = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 50;
  localparam int SCL_PERIOD_NS  = 400;
  // one bit is four quarters, each quarter a whole number of clocks
  localparam int QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [3:0] QUARTER_LAST = 4'(QUARTER_CYCLES - 1);
  localparam logic [1:0] QTR_LAST     = 2'h3;
  localparam logic [2:0] BIT_LAST     = 3'h7;

  // ****************************************************************
  // field layouts and reset values
  // ****************************************************************
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;

  typedef struct packed {
    logic       controller_enable;
    logic       start;
    logic       stop;
    logic       nak_next;
    logic [3:0] rsvd;
  } i2csf_ctrl_type;

  typedef struct packed {
    logic tx_empty;
    logic rx_full;
    logic ack;
    logic ten_bit_address_flag;
    logic read_direction_flag;
    logic address_shift_active;
    logic data_shift_active;
    logic nack_interrupt_flag;
  } i2csf_status_type;

  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] TX_DATA_RESET  = 8'h00;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // interrupt status / mask bit positions
  localparam int IRQ_NACK = 0;
  localparam int IRQ_TXE  = 1;
  localparam int IRQ_RXF  = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_DATA,
    ST_DATA_ACK,
    ST_HOLD,
    ST_STOP
  } i2csf_state_type;

endpackage

/* File: core/i2csf_sync.sv */
/*
 * i2csf_sync: two-flop synchronisers for the bus lines, plus a rise marker.
 * assumes the lines are asynchronous to i_clk; output bits lag by two clocks.
 */
`timescale 1ns/1ps
module i2csf_sync (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic [1:0] i_lines,
  output logic      [1:0] o_lines,
  output logic      [1:0] o_rise
);

  // ****************************************************************
  // per line synchroniser
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_line
      logic meta_q;
      logic sync_q;
      logic last_q;
      // idle bus lines float high
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
          last_q <= 1'b1;
        end else begin
          meta_q <= i_lines[g];
          sync_q <= meta_q;
          last_q <= sync_q;
        end
      end
      assign o_lines[g] = sync_q;
      assign o_rise[g]  = sync_q & ~last_q;  // edge seen past the second flop only
    end
  endgenerate

endmodule

/* File: core/i2csf_top.sv */
/*
 * i2csf_top: i2c master sequencer with its status flags, behind an AXI4-Lite
 * slave, with one level interrupt.
 * assumes open-drain bus lines resolved outside (oe high pulls the line low),
 * pull-ups on both lines, and a single 20 MHz clock.
 */
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module i2csf_top (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // axi4-lite slave
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  // i2c bus, open drain
  input  wire logic        i_scl,
  output logic             o_scl,
  output logic             o_scl_oe,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe,
  output logic             o_irq
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  i2csf_pkg::i2csf_state_type state_q, state_d;
  i2csf_pkg::i2csf_ctrl_type  ctrl_q, ctrl_d, wr_ctrl_val;
  i2csf_pkg::i2csf_status_type status_w;
  logic [3:0]  div_q;
  logic [1:0]  qtr_q;
  logic [2:0]  bit_q;
  logic [7:0]  shift_q, shift_d, tx_data_q, rx_data_q;
  logic        tx_full_q, rx_full_q, ack_q, ten_bit_q, rd_q, nack_q;
  logic [2:1]  irq_stat_q;
  logic [2:0]  irq_mask_q, irq_view;
  logic        aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [1:0]  lines_s, rise_s;
  logic        scl_s, sda_s;

  // ****************************************************************
  // bus line synchronisers
  // ****************************************************************
  i2csf_sync u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_lines ({i_sda, i_scl}),
    .o_lines (lines_s),
    .o_rise  (rise_s)
  );
  assign scl_s = lines_s[0];
  assign sda_s = lines_s[1];

  // ****************************************************************
  // bit timing
  // ****************************************************************
  // released-scl quarters wait for the line to be seen high (stretching)
  logic scl_rel, sda_low, stretch, tick, bit_end;
  assign stretch = scl_rel && !scl_s && !rise_s[0] && (state_q != i2csf_pkg::ST_IDLE);
  assign tick    = (div_q == i2csf_pkg::QUARTER_LAST) && !stretch;
  assign bit_end = tick && (qtr_q == i2csf_pkg::QTR_LAST);

  // quarter divider, one enable pulse per quarter
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      div_q <= 4'h0;
      qtr_q <= 2'h0;
    end else if (tick) begin
      div_q <= 4'h0;
      qtr_q <= qtr_q + 2'h1;
    end else if (div_q != i2csf_pkg::QUARTER_LAST) begin
      div_q <= div_q + 4'h1;
    end
  end

  // ****************************************************************
  // line drive per state and quarter
  // ****************************************************************
  logic tx_bit, rx_dir_data;
  assign rx_dir_data = rd_q && (state_q == i2csf_pkg::ST_DATA);
  assign tx_bit      = (state_q == i2csf_pkg::ST_ADDR) || ((state_q == i2csf_pkg::ST_DATA) && !rd_q);
  always_comb begin
    scl_rel = 1'b1;
    sda_low = 1'b0;
    case (state_q)
      i2csf_pkg::ST_IDLE: begin
        scl_rel = 1'b1;
      end
      i2csf_pkg::ST_START: begin
        sda_low = qtr_q[1];                       // sda falls while scl high
      end
      i2csf_pkg::ST_STOP: begin
        scl_rel = (qtr_q != 2'h0);
        sda_low = (qtr_q != i2csf_pkg::QTR_LAST); // sda rises while scl high
      end
      i2csf_pkg::ST_HOLD: begin
        scl_rel = 1'b0;                           // bus paused with scl low
      end
      i2csf_pkg::ST_DATA_ACK: begin
        scl_rel = qtr_q[1];
        sda_low = rd_q && !ctrl_q.nak_next;       // our answer on a read
      end
      default: begin
        scl_rel = qtr_q[1];
        sda_low = tx_bit && !shift_q[7] && !rx_dir_data;
      end
    endcase
  end

  // open drain outputs, registered; sda trails scl by one clock so data never moves on an scl fall
  logic sda_low_q;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_scl_oe  <= 1'b0;
      sda_low_q <= 1'b0;
      o_sda_oe  <= 1'b0;
    end else begin
      o_scl_oe  <= !scl_rel;
      sda_low_q <= sda_low;
      o_sda_oe  <= sda_low_q;
    end
  end
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;

  // ****************************************************************
  // sequencer
  // ****************************************************************
  logic got_ack, nack_event, load_tx, start_done, stop_done, rx_store, nak_sent;
  logic go_stop, go_start, go_data;
  assign got_ack    = !sda_s;
  // a nack on a read is the one we send ourselves
  assign nak_sent   = (state_q == i2csf_pkg::ST_DATA_ACK) && rd_q && ctrl_q.nak_next;
  assign nack_event = bit_end && (((state_q == i2csf_pkg::ST_ADDR_ACK) && !got_ack) ||
                      ((state_q == i2csf_pkg::ST_DATA_ACK) && !rd_q && !got_ack) || nak_sent);
  assign go_stop    = ctrl_q.stop;
  assign go_start   = ctrl_q.start && tx_full_q;
  assign go_data    = !nack_q && ack_q && (rd_q ? !rx_full_q : tx_full_q);
  assign start_done = bit_end && (state_q == i2csf_pkg::ST_START);
  assign stop_done  = bit_end && (state_q == i2csf_pkg::ST_STOP);
  assign rx_store   = bit_end && rx_dir_data && (bit_q == i2csf_pkg::BIT_LAST);

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    load_tx = 1'b0;
    if (bit_end) begin
      shift_d = {shift_q[6:0], sda_s};
      case (state_q)
        i2csf_pkg::ST_IDLE: begin
          if (ctrl_q.controller_enable && go_start) begin
            state_d = i2csf_pkg::ST_START;
            load_tx = 1'b1;
          end
        end
        i2csf_pkg::ST_START: begin
          state_d = i2csf_pkg::ST_ADDR;
          shift_d = shift_q;
        end
        i2csf_pkg::ST_ADDR: begin
          if (bit_q == i2csf_pkg::BIT_LAST) begin
            state_d = i2csf_pkg::ST_ADDR_ACK;
          end
        end
        i2csf_pkg::ST_DATA: begin
          if (bit_q == i2csf_pkg::BIT_LAST) begin
            state_d = i2csf_pkg::ST_DATA_ACK;
          end
        end
        i2csf_pkg::ST_ADDR_ACK, i2csf_pkg::ST_DATA_ACK: begin
          state_d = i2csf_pkg::ST_HOLD;
        end
        i2csf_pkg::ST_HOLD: begin
          if (go_stop) begin
            state_d = i2csf_pkg::ST_STOP;
          end else if (go_start) begin
            state_d = i2csf_pkg::ST_START;
            load_tx = 1'b1;
          end else if (go_data) begin
            state_d = i2csf_pkg::ST_DATA;
            load_tx = !rd_q;
          end
        end
        i2csf_pkg::ST_STOP: begin
          state_d = i2csf_pkg::ST_IDLE;
        end
        default: begin
          state_d = i2csf_pkg::ST_IDLE;
        end
      endcase
      if (load_tx) begin
        shift_d = tx_data_q;
      end
    end
    if (!ctrl_q.controller_enable) begin
      state_d = i2csf_pkg::ST_IDLE;
    end
  end

  // sequencer state and shift register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= i2csf_pkg::ST_IDLE;
      shift_q <= 8'h00;
      bit_q   <= 3'h0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      bit_q   <= (state_d != state_q) ? 3'h0 : (bit_end ? bit_q + 3'h1 : bit_q);
    end
  end

  // ****************************************************************
  // status flags
  // ****************************************************************
  logic sw_sets_ss, wr_ctrl, wr_data, wr_stat, wr_mask, rd_data, data_taken;
  assign sw_sets_ss = wr_ctrl && (wr_ctrl_val.start || wr_ctrl_val.stop);
  assign data_taken = load_tx;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rd_q      <= 1'b0;
      ten_bit_q <= 1'b0;
      ack_q     <= 1'b0;
      nack_q    <= 1'b0;
    end else begin
      if (load_tx && (state_d == i2csf_pkg::ST_START)) begin
        rd_q <= shift_d[0];
      end
      if (load_tx && (state_d == i2csf_pkg::ST_START)) begin
        ten_bit_q <= (shift_d[7:3] == i2csf_pkg::TEN_BIT_PREFIX);
      end else if (bit_end && (state_q == i2csf_pkg::ST_ADDR_ACK)) begin
        ten_bit_q <= 1'b0;
      end
      if (!ctrl_q.controller_enable || nack_event) begin
        ack_q <= 1'b0;
      end else if (bit_end && ((state_q == i2csf_pkg::ST_ADDR_ACK) || (state_q == i2csf_pkg::ST_DATA_ACK))) begin
        ack_q <= 1'b1;
      end
      // nack only with start and stop idle
      if (nack_event && !ctrl_q.start && !ctrl_q.stop) begin
        nack_q <= 1'b1;
      // cleared by setting start or stop
      end else if (sw_sets_ss) begin
        nack_q <= 1'b0;
      end else if (stop_done) begin
        nack_q <= 1'b0;
      end
    end
  end

  assign status_w.address_shift_active = (state_q == i2csf_pkg::ST_ADDR);
  assign status_w.data_shift_active    = (state_q == i2csf_pkg::ST_DATA);
  assign status_w.tx_empty             = !tx_full_q;
  assign status_w.rx_full              = rx_full_q;
  assign status_w.ack                  = ack_q;
  assign status_w.ten_bit_address_flag = ten_bit_q;
  assign status_w.read_direction_flag  = rd_q;
  assign status_w.nack_interrupt_flag  = nack_q;

  // ****************************************************************
  // control, data and interrupt registers
  // ****************************************************************
  assign wr_ctrl_val = i2csf_pkg::i2csf_ctrl_type'(wdata_q[7:0]);
  always_comb begin
    ctrl_d = ctrl_q;
    if (start_done) begin
      ctrl_d.start = 1'b0;
    end
    if (stop_done) begin
      ctrl_d.stop = 1'b0;
    end
    if (bit_end && nak_sent) begin
      ctrl_d.nak_next = 1'b0;
    end
    if (wr_ctrl) begin
      ctrl_d      = wr_ctrl_val;
      ctrl_d.rsvd = 4'h0;
    end
  end

  assign irq_view = {irq_stat_q, nack_q};
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_q     <= i2csf_pkg::i2csf_ctrl_type'(i2csf_pkg::CTRL_RESET);
      tx_data_q  <= i2csf_pkg::TX_DATA_RESET;
      tx_full_q  <= 1'b0;
      rx_data_q  <= 8'h00;
      rx_full_q  <= 1'b0;
      irq_stat_q <= 2'h0;
      irq_mask_q <= i2csf_pkg::IRQ_MASK_RESET;
      o_irq      <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      tx_data_q <= wr_data ? wdata_q[7:0] : tx_data_q;
      tx_full_q <= wr_data || (tx_full_q && !data_taken);
      rx_data_q <= rx_store ? shift_d : rx_data_q;
      // set wins over the clear by a data read
      rx_full_q <= rx_store || (rx_full_q && !rd_data);
      irq_stat_q[i2csf_pkg::IRQ_TXE] <= data_taken ||
        (irq_stat_q[i2csf_pkg::IRQ_TXE] && !(wr_stat && wdata_q[i2csf_pkg::IRQ_TXE]));
      irq_stat_q[i2csf_pkg::IRQ_RXF] <= rx_store ||
        (irq_stat_q[i2csf_pkg::IRQ_RXF] && !(wr_stat && wdata_q[i2csf_pkg::IRQ_RXF]));
      irq_mask_q <= wr_mask ? wdata_q[2:0] : irq_mask_q;
      o_irq      <= |(irq_view & irq_mask_q);
    end
  end

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  logic wr_fire, wr_hit, rd_fire, rd_hit, aw_hs, w_hs;
  assign o_awready = !aw_held_q && !bvalid_q;
  assign o_wready  = !w_held_q && !bvalid_q;
  assign aw_hs     = i_awvalid && o_awready;
  assign w_hs      = i_wvalid && o_wready;
  assign wr_fire   = aw_held_q && w_held_q && !bvalid_q;
  assign wr_hit    = (awaddr_q == i2csf_pkg::ADDR_CTRL) || (awaddr_q == i2csf_pkg::ADDR_STATUS) ||
                     (awaddr_q == i2csf_pkg::ADDR_DATA) || (awaddr_q == i2csf_pkg::ADDR_IRQ_STAT) ||
                     (awaddr_q == i2csf_pkg::ADDR_IRQ_MASK);
  assign wr_ctrl   = wr_fire && wstrb_q[0] && (awaddr_q == i2csf_pkg::ADDR_CTRL);
  assign wr_data   = wr_fire && wstrb_q[0] && (awaddr_q == i2csf_pkg::ADDR_DATA);
  assign wr_stat   = wr_fire && wstrb_q[0] && (awaddr_q == i2csf_pkg::ADDR_IRQ_STAT);
  assign wr_mask   = wr_fire && wstrb_q[0] && (awaddr_q == i2csf_pkg::ADDR_IRQ_MASK);
  assign o_arready = !rvalid_q;
  assign rd_fire   = i_arvalid && o_arready;
  assign rd_data   = rd_fire && (i_araddr == i2csf_pkg::ADDR_DATA);
  assign rd_hit    = (i_araddr == i2csf_pkg::ADDR_CTRL) || (i_araddr == i2csf_pkg::ADDR_STATUS) ||
                     (i_araddr == i2csf_pkg::ADDR_DATA) || (i_araddr == i2csf_pkg::ADDR_IRQ_STAT) ||
                     (i_araddr == i2csf_pkg::ADDR_IRQ_MASK);

  // read data select
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (i_araddr)
      i2csf_pkg::ADDR_CTRL:     rd_byte = ctrl_q;
      i2csf_pkg::ADDR_STATUS:   rd_byte = status_w;
      i2csf_pkg::ADDR_DATA:     rd_byte = rx_data_q;
      i2csf_pkg::ADDR_IRQ_STAT: rd_byte = {5'h00, irq_view};
      i2csf_pkg::ADDR_IRQ_MASK: rd_byte = {5'h00, irq_mask_q};
      default:                  rd_byte = 8'h00;
    endcase
  end

  // write address/data capture in either order, then one response
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= i2csf_pkg::RESP_OKAY;
    end else begin
      aw_held_q <= aw_hs || (aw_held_q && !wr_fire);
      w_held_q  <= w_hs || (w_held_q && !wr_fire);
      awaddr_q  <= aw_hs ? {i_awaddr[7:2], 2'h0} : awaddr_q;
      wdata_q   <= w_hs ? i_wdata : wdata_q;
      wstrb_q   <= w_hs ? i_wstrb : wstrb_q;
      bvalid_q  <= wr_fire || (bvalid_q && !i_bready);
      bresp_q   <= wr_fire ? (wr_hit ? i2csf_pkg::RESP_OKAY : i2csf_pkg::RESP_SLVERR) : bresp_q;
    end
  end

  // read answer one edge after the address is taken
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= i2csf_pkg::RESP_OKAY;
    end else begin
      rvalid_q <= rd_fire || (rvalid_q && !i_rready);
      rdata_q  <= rd_fire ? {24'h000000, rd_byte} : rdata_q;
      rresp_q  <= rd_fire ? (rd_hit ? i2csf_pkg::RESP_OKAY : i2csf_pkg::RESP_SLVERR) : rresp_q;
    end
  end

  assign o_bvalid = bvalid_q;
  assign o_bresp  = bresp_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata  = rdata_q;
  assign o_rresp  = rresp_q;

endmodule

/* File: sim/i2csf_slave.sv */
/* i2csf_slave: behavioural i2c slave that acks or refuses and serves one byte.
   assumes wired-and bus lines with pull-ups resolved in the bench. */
`timescale 1ns/1ps
module i2csf_slave (
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic       i_nack,
  input  wire logic [7:0] i_byte,
  output logic            o_sda_oe
);
  int         cnt = 0;
  logic       rd = 1'b0;
  logic       first = 1'b1;
  logic       go = 1'b0;
  logic [7:0] sh = 8'h00;
  initial o_sda_oe = 1'b0;
  // start and stop framing restart the byte count
  always @(i_sda) if (i_scl) begin
    cnt = 0;
    rd = 1'b0;
    first = 1'b1;
    o_sda_oe = 1'b0;
  end
  // shift in on scl rise
  always @(posedge i_scl) begin
    sh = {sh[6:0], i_sda};
    cnt = cnt + 1;
  end
  // ack after address or written byte, data bits on reads, release otherwise
  always @(negedge i_scl) begin
    if (cnt == 8) begin
      if (first) rd = sh[0];
      o_sda_oe = (first || !rd) && !i_nack;
      first = 1'b0;
    end else begin
      if (cnt == 9) begin
        cnt = 0;
        go = !sh[0];
      end
      o_sda_oe = rd && go && cnt < 8 && !i_byte[3'(7 - cnt)];
    end
  end
endmodule

/* File: sim/i2csf_chk.sv */
/* i2csf_chk: register bus and pin checks on the top ports.
   assumes one clock domain and an active high reset. */
`timescale 1ns/1ps
module i2csf_chk (
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [1:0]  o_bresp,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic        o_scl,
  input wire logic        o_sda,
  input wire logic        o_scl_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ********
  // handshake and pin checks
  // ********
  chk_b_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  chk_r_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  chk_b_done: assert property (o_bvalid && i_bready |=> !o_bvalid) else $error("write response stuck");
  chk_r_done: assert property (o_rvalid && i_rready |=> !o_rvalid) else $error("read data stuck");
  chk_ar_block: assert property (o_arready == !o_rvalid) else $error("read address ready wrong");
  chk_aw_block: assert property (o_bvalid |-> !o_awready && !o_wready) else $error("write taken early");
  chk_write_lat: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid)
    else $error("write response late");
  chk_read_lat: assert property (i_arvalid && o_arready |=> o_rvalid) else $error("read response late");
  chk_rdata_top: assert property (o_rvalid |-> o_rdata[31:8] == 24'h000000) else $error("read data upper set");
  chk_open_drain: assert property (o_scl == 1'b0 && o_sda == 1'b0) else $error("bus line driven high");
  chk_scl_low: assert property ($rose(o_scl_oe) |=> o_scl_oe [*3]) else $error("scl low phase short");
endmodule
bind i2csf_top i2csf_chk u_i2csf_chk (.i_clk(i_clk), .i_reset(i_reset), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid),
  .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
  .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_scl(o_scl), .o_sda(o_sda),
  .o_scl_oe(o_scl_oe));

/* File: sim/i2c_controller_status_flags_tb.sv */
/* i2c_controller_status_flags_tb: register-level tests of the status flags.
   assumes i2csf_top, i2csf_slave and the bound checker. */
`timescale 1ns/1ps
module i2c_controller_status_flags_tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        nack = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, s_oe, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  rv, seen;
  int          miscompares = 0;
  int          checked = 0;
  wire         scl = ~scl_oe;
  wire         sda = ~(sda_oe | s_oe);
  // clock
  always #25 clk = ~clk;
  i2csf_top u_i2csf_top (.i_clk(clk), .i_reset(reset), .i_awvalid(awvalid), .o_awready(awready),
    .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .i_scl(scl), .o_scl(), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda(), .o_sda_oe(sda_oe), .o_irq(irq));
  i2csf_slave u_i2csf_slave (.i_scl(scl), .i_sda(sda), .i_nack(nack), .i_byte(8'h3c), .o_sda_oe(s_oe));
  // ********
  // bus tasks
  // ********
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = i2csf_pkg::RESP_OKAY);
    logic ah, dh;
    ah = 1'b1;
    dh = 1'b1;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (ah || dh) begin
      @(posedge clk);
      if (ah && awready) begin
        ah = 1'b0;
        awvalid <= 1'b0;
      end
      if (dh && wready) begin
        dh = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    cmp(32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er = i2csf_pkg::RESP_OKAY);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    rv = rdata[7:0];
    cmp(32'(rresp), 32'(er));
  endtask
  task automatic chkr(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    cmp(32'(rv), 32'(exp));
  endtask
  // poll a register until masked bits match, collecting every bit seen
  task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
    seen = 8'h00;
    for (int k = 0; k < 500; k++) begin
      rd(a);
      seen = seen | rv;
      if ((rv & m) === v) break;
    end
    cmp(32'(rv & m), 32'(v));
  endtask
  task automatic final_report;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #4000000;
    miscompares++;
    final_report;
  end
  // ********
  // test sequence
  // ********
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chkr(i2csf_pkg::ADDR_CTRL, 8'h00);
    chkr(i2csf_pkg::ADDR_IRQ_MASK, 8'h00);
    rd(8'h14, i2csf_pkg::RESP_SLVERR);
    wr(8'h14, 8'hff, i2csf_pkg::RESP_SLVERR);
    wr(i2csf_pkg::ADDR_STATUS, 8'h1f);
    chkr(i2csf_pkg::ADDR_STATUS, 8'h80);
    // write transfer, slave refuses the data byte
    wr(i2csf_pkg::ADDR_IRQ_MASK, 8'h01);
    wr(i2csf_pkg::ADDR_DATA, 8'ha4);
    wr(i2csf_pkg::ADDR_CTRL, 8'hc0);
    poll(i2csf_pkg::ADDR_STATUS, 8'h26, 8'h20);
    cmp(32'(seen[3:1]), 32'h2);
    cmp(32'(seen[4]), 32'h0);
    nack <= 1'b1;
    wr(i2csf_pkg::ADDR_DATA, 8'h5a);
    poll(i2csf_pkg::ADDR_STATUS, 8'h01, 8'h01);
    cmp(32'({seen[1], rv[5]}), 32'h2);
    cmp(32'(irq), 32'h1);
    wr(i2csf_pkg::ADDR_IRQ_STAT, 8'h01);
    wr(i2csf_pkg::ADDR_IRQ_MASK, 8'h00);
    @(posedge clk);
    cmp(32'(irq), 32'h0);
    wr(i2csf_pkg::ADDR_IRQ_MASK, 8'h01);
    @(posedge clk);
    cmp(32'(irq), 32'h1);
    nack <= 1'b0;
    wr(i2csf_pkg::ADDR_CTRL, 8'ha0);
    poll(i2csf_pkg::ADDR_CTRL, 8'h20, 8'h00);
    chkr(i2csf_pkg::ADDR_STATUS, 8'h80);
    cmp(32'(irq), 32'h0);
    // ten bit prefix, then disable clears ack
    wr(i2csf_pkg::ADDR_DATA, 8'hf2);
    wr(i2csf_pkg::ADDR_CTRL, 8'hc0);
    poll(i2csf_pkg::ADDR_STATUS, 8'h26, 8'h20);
    cmp(32'({seen[4], rv[4]}), 32'h2);
    chkr(i2csf_pkg::ADDR_STATUS, 8'ha0);
    wr(i2csf_pkg::ADDR_CTRL, 8'h00);
    chkr(i2csf_pkg::ADDR_STATUS, 8'h80);
    // read of one byte with a nak sent at its end
    wr(i2csf_pkg::ADDR_DATA, 8'h4b);
    wr(i2csf_pkg::ADDR_CTRL, 8'hd0);
    poll(i2csf_pkg::ADDR_STATUS, 8'h01, 8'h01);
    cmp(32'({seen[3], seen[1]}), 32'h3);
    chkr(i2csf_pkg::ADDR_DATA, 8'h3c);
    wr(i2csf_pkg::ADDR_CTRL, 8'ha0);
    poll(i2csf_pkg::ADDR_CTRL, 8'h20, 8'h00);
    chkr(i2csf_pkg::ADDR_STATUS, 8'h88);
    final_report;
  end
endmodule
